/* File: pkg/flash_host_pkg.sv */
package flash_host_pkg;

  localparam int          ADDR_W      = 13;
  localparam int          DATA_W      = 16;
  localparam int          CLK_NS      = 100;
  // power-on reset pulse driven to the device, least time
  localparam int          POR_NS      = 1000;
  // strobe width granted to each access (wait states), least time
  localparam int          ACCESS_NS   = 100;
  localparam logic [7:0]  POR_CYC     = 8'((POR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  ACCESS_CYC  = 8'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
  // extra strobe cycles so read data has passed the input synchroniser
  localparam logic [7:0]  SYNC_CYC    = 8'h02;
  localparam logic        WIDE_RST    = 1'b1;
  localparam logic        KEY_RST     = 1'b0;
  localparam logic        MUX_RST     = 1'b0;
  localparam logic [1:0]  CASCADE_RST = 2'h0;

  typedef enum logic [7:0] {
    S_RESET      = 8'h01,
    S_WAIT_READY = 8'h02,
    S_MUX_ENTRY  = 8'h04,
    S_IDLE       = 8'h08,
    S_ADDR       = 8'h10,
    S_SETUP      = 8'h20,
    S_STROBE     = 8'h40,
    S_DONE       = 8'h80
  } host_state_t;

endpackage

/* File: src/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  input  wire logic [WIDTH-1:0] reset_val_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  // two flops; the first is read only by the second
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_reg <= '1;
      sync_o   <= '1;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule

/* File: src/flash_disk_host_bus_port.sv */
`timescale 1ns/10ps
// Summary of operation
// - host drives read, write strobes and the decoded chip select.
// - host stretches each strobe with enough wait states for device timing.
// - host drives an active-low power-on reset; device reset while low.
// - single device: both cascade position inputs are held low outside mux mode.
// - readiness output marks first access; host waits on it after reset.
// - host makes that falling edge after reset, before the first read.
// - host interrupt input uses the same edge or level sensitivity.
module flash_disk_host_bus_port (
  input  wire logic                                clk_sys_i,
  input  wire logic                                reset_n_i,
  input  wire logic                                start_i,
  input  wire logic                                write_i,
  input  wire logic [flash_host_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [flash_host_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic                                mux_mode_i,
  input  wire logic                                wide_bus_i,
  input  wire logic                                key_enable_i,
  input  wire logic                                deep_powerdown_i,
  input  wire logic                                irq_level_i,
  output logic      [flash_host_pkg::DATA_W-1:0]   rdata_o,
  output logic                                     done_o,
  output logic                                     error_o,
  output logic                                     ready_o,
  output logic                                     irq_o,
  output logic                                     dma_req_o,
  output logic      [flash_host_pkg::ADDR_W-1:0]   dev_addr_o,
  output logic      [flash_host_pkg::DATA_W-1:0]   dev_data_o,
  output logic                                     dev_data_oe_n_o,
  input  wire logic [flash_host_pkg::DATA_W-1:0]   dev_data_i,
  output logic                                     dev_ce_n_o,
  output logic                                     dev_oe_n_o,
  output logic                                     dev_we_n_o,
  output logic                                     power_on_reset_in_n_o,
  output logic      [1:0]                          cascade_position_o,
  output logic                                     key_lock_o,
  output logic                                     bus_width_16_o,
  input  wire logic                                ready_busy_n_i,
  input  wire logic                                dma_request_n_i,
  input  wire logic                                irq_n_i
);
  import flash_host_pkg::*;

  host_state_t         state_reg;
  host_state_t         state_next;
  logic [7:0]          cnt_reg;
  logic [ADDR_W-1:0]   addr_reg;
  logic [DATA_W-1:0]   wdata_reg;
  logic                wr_reg;
  logic                wide_reg;
  logic                mux_reg;
  logic                irq_prev_reg;
  logic [DATA_W+2:0]   pins_s;
  logic [DATA_W-1:0]   data_s;
  logic                busy_n_s;
  logic                dma_n_s;
  logic                irq_n_s;
  logic                illegal;
  logic [ADDR_W-1:0]   addr_cur;
  logic [DATA_W-1:0]   wdata_cur;
  logic                wr_cur;

  function automatic logic in_access(input host_state_t s);
    return (s == S_ADDR) || (s == S_SETUP) || (s == S_STROBE) || (s == S_DONE);
  endfunction

  pin_sync #(.WIDTH(DATA_W + 3)) u_sync (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .async_i     ({dev_data_i, ready_busy_n_i, dma_request_n_i, irq_n_i}),
    .reset_val_i ('1),
    .sync_o      (pins_s)
  );
  assign data_s   = pins_s[DATA_W+2:3];
  assign busy_n_s = pins_s[2];
  assign dma_n_s  = pins_s[1];
  assign irq_n_s  = pins_s[0];

  // odd address in 16-bit mode is refused
  assign illegal = wide_reg && addr_i[0];

  // on the taking edge the request is not yet in its registers, so pins read it live
  assign addr_cur  = (state_reg == S_IDLE) ? addr_i : addr_reg;
  assign wdata_cur = (state_reg == S_IDLE) ? wdata_i : wdata_reg;
  assign wr_cur    = (state_reg == S_IDLE) ? write_i : wr_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_RESET: begin
        if (cnt_reg == POR_CYC - 8'h01) state_next = S_WAIT_READY;
      end
      S_WAIT_READY: begin
        if (busy_n_s) state_next = mux_reg ? S_MUX_ENTRY : S_IDLE;
      end
      S_MUX_ENTRY: state_next = S_IDLE;
      S_IDLE: begin
        if (start_i && !illegal) state_next = mux_reg ? S_ADDR : S_SETUP;
      end
      S_ADDR: state_next = S_SETUP;
      S_SETUP: state_next = S_STROBE;
      S_STROBE: begin
        if (cnt_reg == (wr_reg ? ACCESS_CYC : ACCESS_CYC + SYNC_CYC) - 8'h01) begin
          state_next = S_DONE;
        end
      end
      S_DONE: state_next = S_IDLE;
      default: state_next = S_RESET;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= S_RESET;
      cnt_reg   <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= (state_next != state_reg) ? 8'h00 : cnt_reg + 8'h01;
    end
  end

  // straps are caught while the device is held in reset
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wide_reg       <= WIDE_RST;
      mux_reg        <= MUX_RST;
      key_lock_o     <= KEY_RST;
      bus_width_16_o <= WIDE_RST;
    end else if (state_reg == S_RESET) begin
      wide_reg       <= wide_bus_i;
      mux_reg        <= mux_mode_i;
      key_lock_o     <= key_enable_i;
      bus_width_16_o <= wide_bus_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_reg  <= '0;
      wdata_reg <= '0;
      wr_reg    <= 1'b0;
    end else if (state_reg == S_IDLE && start_i) begin
      addr_reg  <= addr_i;
      wdata_reg <= wdata_i;
      wr_reg    <= write_i;
    end
  end

  // device pins, each from a flop
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      power_on_reset_in_n_o <= 1'b0;
      dev_ce_n_o            <= 1'b1;
      dev_oe_n_o            <= 1'b1;
      dev_we_n_o            <= 1'b1;
      cascade_position_o    <= CASCADE_RST;
      dev_addr_o            <= '0;
      dev_data_o            <= '0;
      dev_data_oe_n_o       <= 1'b1;
    end else begin
      power_on_reset_in_n_o <= (state_next != S_RESET);
      dev_ce_n_o            <= !in_access(state_next);
      dev_oe_n_o            <= !(state_next == S_STROBE && !wr_reg);
      dev_we_n_o            <= !(state_next == S_STROBE && wr_reg);
      // upper bit is address-valid in mux mode, else single-device strap
      cascade_position_o    <= {mux_reg ? !(state_next == S_MUX_ENTRY ||
                                            state_next == S_ADDR) : 1'b0,
                                1'b0};
      if (state_next == S_IDLE || state_next == S_WAIT_READY) begin
        dev_addr_o <= {{(ADDR_W-1){1'b0}}, deep_powerdown_i};
      end else begin
        dev_addr_o <= addr_cur;
      end
      if (state_next == S_ADDR) begin
        dev_data_o <= {{(DATA_W-ADDR_W){1'b0}}, addr_cur};
      end else begin
        dev_data_o <= wdata_cur;
      end
      dev_data_oe_n_o <= !(state_next == S_ADDR ||
                           (wr_cur && in_access(state_next) && state_next != S_ADDR));
    end
  end

  // user side answers
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= '0;
      done_o  <= 1'b0;
      error_o <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      done_o  <= (state_next == S_DONE);
      error_o <= (state_reg == S_IDLE) && start_i && illegal;
      ready_o <= (state_next == S_IDLE);
      if (state_next == S_DONE && !wr_reg) begin
        // 8-bit mode: the addressed byte always comes on the low lane
        rdata_o <= wide_reg ? data_s : {8'h00, data_s[7:0]};
      end
    end
  end

  // interrupt and dma pins, interrupt sensitivity matched to the device setting
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_prev_reg <= 1'b1;
      irq_o        <= 1'b0;
      dma_req_o    <= 1'b0;
    end else begin
      irq_prev_reg <= irq_n_s;
      irq_o        <= irq_level_i ? !irq_n_s : (irq_prev_reg && !irq_n_s);
      dma_req_o    <= !dma_n_s;
    end
  end

  sequence seq_mux_entry;
    (state_reg == S_WAIT_READY) ##1 (state_reg == S_MUX_ENTRY);
  endsequence

  sequence seq_addr_phase;
    (state_reg == S_ADDR) ##1 (state_reg == S_SETUP);
  endsequence

  a_reset_pulse: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(power_on_reset_in_n_o) |-> $past(state_reg) == S_RESET &&
    $past(cnt_reg) == POR_CYC - 8'h01) else $error("device reset pulse width wrong");
  a_reset_held: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_reg == S_RESET) |-> !power_on_reset_in_n_o)
    else $error("device reset not driven low");
  a_no_access_busy: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_reg == S_WAIT_READY && !busy_n_s) |=> dev_ce_n_o)
    else $error("access started while device busy");
  a_ce_before_strobe: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $fell(dev_oe_n_o) || $fell(dev_we_n_o) |-> !$past(dev_ce_n_o))
    else $error("strobe edge without prior chip select");
  a_strobe_width: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $fell(dev_we_n_o) |-> !dev_we_n_o ##1 dev_we_n_o ##1 dev_ce_n_o)
    else $error("write strobe width wrong");
  a_read_width: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $fell(dev_oe_n_o) |-> !dev_oe_n_o[*3] ##1 dev_oe_n_o)
    else $error("read strobe width wrong");
  a_mux_edge_first: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    seq_mux_entry |-> !cascade_position_o[1] ##1 cascade_position_o[1])
    else $error("mux entry edge missing");
  a_addr_on_bus: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    seq_addr_phase |-> $past(dev_data_o) == {{(DATA_W-ADDR_W){1'b0}}, addr_reg} &&
    !$past(dev_data_oe_n_o))
    else $error("address phase wrong on shared bus");
  a_single_strap: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !mux_reg |-> ##1 (cascade_position_o == 2'h0 || $past(mux_reg)))
    else $error("cascade straps not low");
  a_illegal_lane: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_reg == S_IDLE && start_i && illegal) |=> error_o && dev_ce_n_o)
    else $error("illegal lane access not refused");
  a_irq_edge: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (!irq_level_i && $fell(irq_n_s)) |=> irq_o)
    else $error("interrupt edge lost");
endmodule

/* File: tb/flash_dev_model.sv */
`timescale 1ns/10ps
module flash_dev_model (
  input  wire logic        rst_n_i,
  input  wire logic [12:0] addr_i,
  input  wire logic [15:0] data_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [1:0]  cascade_i,
  input  wire logic        wide_i,
  input  wire logic        irq_src_i,
  input  wire logic        dma_src_i,
  output logic      [15:0] data_o,
  output logic             busy_n_o,
  output logic             dma_n_o,
  output logic             irq_n_o
);
  logic [15:0] mem [0:4095];
  logic [12:0] lat;
  logic [12:0] a;
  logic        mux;
  initial data_o = 16'h0;
  initial busy_n_o = 1'b0;
  initial lat = 13'h0;
  assign a = mux ? lat : addr_i;
  assign dma_n_o = ~dma_src_i;
  assign irq_n_o = ~irq_src_i;
  // busy while boot code loads after each reset, never for flash work
  always @(rst_n_i) begin
    busy_n_o = 1'b0;
    mux = 1'b0;
    if (rst_n_i === 1'b1) busy_n_o <= #1500 1'b1;
  end
  always @(negedge cascade_i[1]) begin
    if (rst_n_i === 1'b1) mux = 1'b1;
    #50;
    lat = data_i[12:0];
  end
  always @(posedge we_n_i) if (ce_n_i === 1'b0) begin
    if (wide_i) mem[a[12:1]] = data_i;
    else if (a[0]) mem[a[12:1]][15:8] = data_i[7:0];
    else mem[a[12:1]][7:0] = data_i[7:0];
  end
  // released bus shows the inverse of the last value
  always @(ce_n_i, oe_n_i, a) begin
    if (ce_n_i === 1'b0 && oe_n_i === 1'b0) begin
      if (wide_i) data_o = mem[a[12:1]];
      else data_o = {8'hff, a[0] ? mem[a[12:1]][15:8] : mem[a[12:1]][7:0]};
    end else data_o = ~data_o;
  end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic clk, rst_n, start, wr, mux, wide, key, deep_powerdown, lvl, irq_src, dma_src;
  logic [12:0] addr, daddr;
  logic [15:0] wdata, rdata, ddo, mdo, bus;
  logic done, err, rdy, irq, dma_request_n, doe_n, ce_n, oe_n, we_n, por_n, lock, w16;
  logic busy_n, dma_n, irq_n;
  logic [1:0] casc;
  int errors = 0;
  int compares = 0;
  assign bus = (doe_n === 1'b0) ? ddo : mdo;
  always #50 clk = ~clk;
  flash_disk_host_bus_port i_dut (.clk_sys_i(clk), .reset_n_i(rst_n), .start_i(start),
    .write_i(wr), .addr_i(addr), .wdata_i(wdata), .mux_mode_i(mux), .wide_bus_i(wide),
    .key_enable_i(key), .deep_powerdown_i(deep_powerdown), .irq_level_i(lvl), .rdata_o(rdata),
    .done_o(done), .error_o(err), .ready_o(rdy), .irq_o(irq), .dma_req_o(dma_request_n),
    .dev_addr_o(daddr), .dev_data_o(ddo), .dev_data_oe_n_o(doe_n), .dev_data_i(bus),
    .dev_ce_n_o(ce_n), .dev_oe_n_o(oe_n), .dev_we_n_o(we_n), .power_on_reset_in_n_o(por_n),
    .cascade_position_o(casc), .key_lock_o(lock), .bus_width_16_o(w16),
    .ready_busy_n_i(busy_n), .dma_request_n_i(dma_n), .irq_n_i(irq_n));
  flash_dev_model i_dev (.rst_n_i(por_n), .addr_i(daddr), .data_i(bus), .ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .cascade_i(casc), .wide_i(w16), .irq_src_i(irq_src),
    .dma_src_i(dma_src), .data_o(mdo), .busy_n_o(busy_n), .dma_n_o(dma_n), .irq_n_o(irq_n));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rst_seq(input logic m, input logic w, input logic k);
    int n;
    mux = m; wide = w; key = k; rst_n = 0;
    repeat (8) @(negedge clk);
    chk("por_low", 0, por_n);
    rst_n = 1;
    n = 0;
    while (rdy !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("rdy_wait", 1, n >= 26 && n < 100);
  endtask
  task automatic acc(input logic w, input logic [12:0] a, input logic [15:0] d,
                     input int n_exp, output logic [15:0] q, output logic ce_seen);
    int n;
    ce_seen = 0;
    start = 1; wr = w; addr = a; wdata = d;
    @(negedge clk);
    start = 0;
    if (ce_n === 1'b0) ce_seen = 1;
    n = 1;
    while (done !== 1'b1 && err !== 1'b1 && n < 20) begin
      if (ce_n === 1'b0) ce_seen = 1;
      @(negedge clk);
      n++;
    end
    chk("cycles", 16'(n_exp), 16'(n));
    q = rdata;
    @(negedge clk);
  endtask
  task automatic t_std;
    logic [15:0] q;
    logic c;
    rst_seq(0, 1, 1);
    chk("lock", 1, lock);
    chk("width16", 1, w16);
    chk("casc", 0, casc);
    acc(1, 13'h1ffe, 16'ha55a, 3, q, c);
    acc(1, 13'h0002, 16'h1234, 3, q, c);
    acc(0, 13'h1ffe, 16'h0, 5, q, c);
    chk("rd_top", 16'ha55a, q);
    acc(1, 13'h0003, 16'hffff, 1, q, c);
    chk("odd_no_ce", 0, c);
    acc(0, 13'h0002, 16'h0, 5, q, c);
    chk("rd_kept", 16'h1234, q);
    $display("test std_word done");
  endtask
  task automatic t_pins;
    int p;
    deep_powerdown = 1;
    repeat (2) @(negedge clk);
    chk("dpd_pin", 1, daddr[0]);
    deep_powerdown = 0; lvl = 1; irq_src = 1; dma_src = 1;
    repeat (4) @(negedge clk);
    chk("dpd_pin", 0, daddr[0]);
    chk("irq_lvl", 1, irq);
    chk("dma", 1, dma_request_n);
    irq_src = 0; dma_src = 0;
    repeat (4) @(negedge clk);
    chk("irq_off", 0, irq);
    chk("dma_off", 0, dma_request_n);
    lvl = 0; irq_src = 1; p = 0;
    repeat (8) begin
      @(negedge clk);
      if (irq === 1'b1) p++;
    end
    chk("irq_edge", 1, 16'(p));
    irq_src = 0;
    $display("test pins done");
  endtask
  task automatic t_byte;
    logic [15:0] q;
    logic c;
    rst_seq(0, 0, 0);
    chk("lock", 0, lock);
    chk("width16", 0, w16);
    acc(1, 13'h0004, 16'h00c3, 3, q, c);
    acc(1, 13'h0005, 16'h003c, 3, q, c);
    acc(0, 13'h0004, 16'h0, 5, q, c);
    chk("rd_even", 16'h00c3, q);
    acc(0, 13'h0005, 16'h0, 5, q, c);
    chk("rd_odd", 16'h003c, q);
    $display("test byte done");
  endtask
  task automatic t_mux;
    logic [15:0] q;
    logic c;
    rst_seq(1, 1, 0);
    chk("casc_mux", 16'h2, casc);
    acc(1, 13'h1abc, 16'h5aa5, 4, q, c);
    acc(0, 13'h1ffe, 16'h0, 6, q, c);
    chk("mux_rd_old", 16'ha55a, q);
    acc(0, 13'h1abc, 16'h0, 6, q, c);
    chk("mux_rd_new", 16'h5aa5, q);
    $display("test mux done");
  endtask
  initial begin
    clk = 0; rst_n = 0; start = 0; wr = 0; addr = 13'h0; wdata = 16'h0;
    mux = 0; wide = 1; key = 0; deep_powerdown = 0; lvl = 1; irq_src = 0; dma_src = 0;
    @(negedge clk);
    t_std;
    t_pins;
    t_byte;
    t_mux;
    complete_run;
  end
  initial begin
    #500000;
    errors++;
    complete_run;
  end
endmodule
